// ==== verilog/cwd_core_watchdog.sv ====
// core watchdog timer with its reset-cause register
// assumes one bus clock, a byte register port on that clock, and reset-source
// levels from the reset controller that hold stable past reset release
`include "cwd_cfg.svh"
`default_nettype none

// How it works
// [R1] cause flag captured once reset completes
// [R2] at most one cause flag set
// [R3] write one clears flag, zero ignored
// [R4] bit 7 marks external pin reset
// [R5] cause bits from source, others zero
// [R6] control bit 7 enables, off after reset
// [R7] unserviced period raises interrupt request
// [R8] unacknowledged second period asserts bus acknowledge
// [R9] bus acknowledge sets occurred status bit
// [R10] ordered 0x55 then 0xAA restarts count
// [R11] bit 6 zero selects interrupt action
// [R12] reset action requests reset, sets flag
// [R13] count compared live against selected period
// [R14] software disables, services, reprograms, re-enables
// [R15] control readable always, writes locked pending
// [R16] bits 5-3 select period, reset shortest
// [R17] bit 2 enables acknowledge after period
// [R18] occurred bit cleared by writing one
// [R19] bit 0 flag, write one clears
// [R20] service writes never clear interrupt
// [R21] count per clock, restart on service/disable
// [R22] wrong service value restarts recogniser
module cwd_core_watchdog #(
    parameter logic [39:0] PERIOD_EXP = `CWD_PERIOD_EXP_TABLE
) (
    input  wire logic                mclk_in,
    input  wire logic                arst_n_in,
    input  wire logic                ce_in,
    input  wire cwd_pkg::cwd_req_type reg_req_in,
    output logic [7:0]               reg_rdata_out,
    input  wire logic                src_pin_reset_in,
    input  wire logic                src_wdog_reset_in,
    input  wire logic                int_ack_in,
    output logic                     irq_out,
    output logic                     bus_ack_out,
    output logic                     wdog_reset_req_out
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] period_last(input logic [2:0] sel);
        logic [4:0] e;
        e = PERIOD_EXP[{2'h0, sel} * 5 +: 5];
        return (32'h1 << e) - 32'h1;
    endfunction

    function automatic logic hit_addr(input cwd_pkg::cwd_req_type r,
                                      input logic [7:0] ofs);
        return r.addr == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    cwd_pkg::cwd_ctrl_type      ctrl_reg;
    cwd_pkg::cwd_ctrl_type      ctrl_next;
    cwd_pkg::cwd_cause_type     cause_reg;
    cwd_pkg::cwd_cause_type     cause_next;
    cwd_pkg::cwd_svc_state_type svc_reg;
    cwd_pkg::cwd_svc_state_type svc_next;
    logic [31:0]                cnt_reg;
    logic [31:0]                cnt_next;
    logic                       armed_reg;
    logic                       armed_next;
    logic [1:0]                 capt_reg;
    logic [1:0]                 capt_next;
    logic [1:0]                 pin_sync_reg;
    logic [1:0]                 wdog_sync_reg;
    logic [7:0]                 rdata_reg;
    logic [7:0]                 rdata_next;
    logic                       bus_ack_reg;
    logic                       bus_ack_next;
    logic                       rst_req_reg;
    logic                       rst_req_next;

    logic                       wr_cause;
    logic                       wr_ctrl;
    logic                       wr_svc;
    logic                       svc_done;
    logic                       timeout;

    assign wr_cause = reg_req_in.wr && hit_addr(reg_req_in, `CWD_OFS_CAUSE);
    assign wr_ctrl  = reg_req_in.wr && hit_addr(reg_req_in, `CWD_OFS_CTRL);
    assign wr_svc   = reg_req_in.wr && hit_addr(reg_req_in, `CWD_OFS_SERVICE);

    ////////////////////////////////////////////////////////////////////////
    // reset-source synchronisers

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_sync_reg  <= 2'h0;
            wdog_sync_reg <= 2'h0;
        end else if (ce_in) begin
            pin_sync_reg  <= {pin_sync_reg[0], src_pin_reset_in};
            wdog_sync_reg <= {wdog_sync_reg[0], src_wdog_reset_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset-cause register

    always_comb begin
        cause_next = cause_reg;
        capt_next  = capt_reg;
        if (capt_reg != `CWD_CAPT_DONE) begin
            capt_next = capt_reg + 2'h1;
        end
        if (wr_cause && reg_req_in.wdata[`CWD_PIN_BIT]) begin
            cause_next.pin = 1'b0; // R3
        end
        if (wr_cause && reg_req_in.wdata[`CWD_WDOG_BIT]) begin
            cause_next.wdog = 1'b0; // R3
        end
        // capture comes last so it beats a clear in the same cycle
        if (capt_reg == `CWD_CAPT_AT) begin // R1
            cause_next.pin  = pin_sync_reg[1]; // R4 R5
            cause_next.wdog = !pin_sync_reg[1] && wdog_sync_reg[1]; // R2 R12
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cause_reg <= `CWD_CAUSE_RESET;
            capt_reg  <= 2'h0;
        end else if (ce_in) begin
            cause_reg <= cause_next;
            capt_reg  <= capt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // service sequence recogniser

    always_comb begin
        svc_next = svc_reg;
        svc_done = 1'b0;
        unique case (svc_reg)
            cwd_pkg::CWD_WAIT_FIRST: begin
                if (wr_svc && reg_req_in.wdata == `CWD_SVC_KEY1) begin
                    svc_next = cwd_pkg::CWD_WAIT_SECOND; // R10
                end
            end
            cwd_pkg::CWD_WAIT_SECOND: begin
                if (wr_svc) begin
                    // any other value drops back to the start
                    svc_next = cwd_pkg::CWD_WAIT_FIRST; // R22
                    svc_done = reg_req_in.wdata == `CWD_SVC_KEY2; // R10
                end
            end
            default: begin
                svc_next = cwd_pkg::CWD_WAIT_FIRST;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            svc_reg <= cwd_pkg::CWD_WAIT_FIRST;
        end else if (ce_in) begin
            svc_reg <= svc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time-out counter

    // >= rather than == so a shortened period fires at once
    assign timeout = ctrl_reg.en && (cnt_reg >= period_last(ctrl_reg.period)); // R13 R16

    always_comb begin
        if (!ctrl_reg.en || svc_done || timeout) begin
            cnt_next = 32'h0; // R21
        end else begin
            cnt_next = cnt_reg + 32'h1; // R21
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_reg <= 32'h0;
        end else if (ce_in) begin
            cnt_reg <= cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register, interrupt and bus acknowledge

    always_comb begin
        ctrl_next    = ctrl_reg;
        armed_next   = armed_reg;
        bus_ack_next = 1'b0;
        rst_req_next = 1'b0;
        // configuration bits locked while a time-out is pending
        if (wr_ctrl && !ctrl_reg.tif) begin // R15
            ctrl_next.en     = reg_req_in.wdata[`CWD_EN_BIT]; // R6
            ctrl_next.action = reg_req_in.wdata[`CWD_ACT_BIT]; // R11
            ctrl_next.period = reg_req_in.wdata[`CWD_PER_LSB +: 3]; // R16
            ctrl_next.ack_en = reg_req_in.wdata[`CWD_ACKEN_BIT]; // R17
        end
        if (wr_ctrl && reg_req_in.wdata[`CWD_ACKF_BIT]) begin
            ctrl_next.ack_flag = 1'b0; // R18
        end
        if (wr_ctrl && reg_req_in.wdata[`CWD_TIF_BIT]) begin // R20
            ctrl_next.tif = 1'b0; // R19
            armed_next    = 1'b0;
        end
        if (int_ack_in) begin
            armed_next = 1'b0; // R8
        end
        // events after the clears: a set wins over a clear
        if (timeout) begin
            if (!ctrl_reg.tif) begin
                ctrl_next.tif = 1'b1; // R7 R19
                armed_next    = 1'b1;
                // reserved reset action still honoured if programmed
                rst_req_next  = ctrl_reg.action; // R12
            end else if (armed_next && ctrl_reg.ack_en) begin // flag clear disarms too
                bus_ack_next       = 1'b1; // R8 R17
                ctrl_next.ack_flag = 1'b1; // R9
                armed_next         = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_reg    <= `CWD_CTRL_RESET; // R6
            armed_reg   <= 1'b0;
            bus_ack_reg <= 1'b0;
            rst_req_reg <= 1'b0;
        end else if (ce_in) begin
            ctrl_reg    <= ctrl_next;
            armed_reg   <= armed_next;
            bus_ack_reg <= bus_ack_next;
            rst_req_reg <= rst_req_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_req_in.rd) begin
            rdata_next = 8'h00;
            if (hit_addr(reg_req_in, `CWD_OFS_CAUSE)) begin
                rdata_next[`CWD_PIN_BIT]  = cause_reg.pin;
                rdata_next[`CWD_WDOG_BIT] = cause_reg.wdog;
            end else if (hit_addr(reg_req_in, `CWD_OFS_CTRL)) begin
                rdata_next = ctrl_reg; // R15
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= 8'h00;
        end else if (ce_in) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out      = rdata_reg;
    assign irq_out            = ctrl_reg.tif;
    assign bus_ack_out        = bus_ack_reg;
    assign wdog_reset_req_out = rst_req_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    cause_one_hot_a: assert property (!(cause_reg.pin && cause_reg.wdog)) // R2
        else $error("both reset-cause flags set");

    cause_w1c_a: assert property ( // R3
        ce_in && wr_cause && reg_req_in.wdata[`CWD_PIN_BIT] && capt_reg == `CWD_CAPT_DONE
        |=> !cause_reg.pin)
        else $error("pin flag not cleared by write one");

    disabled_idle_a: assert property ( // R21
        ce_in && !ctrl_reg.en |=> cnt_reg == 32'h0 && !bus_ack_out)
        else $error("counter moved while disabled");

    timeout_irq_a: assert property ( // R7
        ce_in && timeout && !ctrl_reg.tif |=> irq_out && cnt_reg == 32'h0)
        else $error("time-out without interrupt");

    irq_cause_a: assert property ($rose(irq_out) |-> $past(ctrl_reg.en)) // R6
        else $error("interrupt while watchdog disabled");

    ack_flag_a: assert property ( // R9
        bus_ack_out |-> ctrl_reg.ack_flag && $past(ctrl_reg.ack_en) && irq_out)
        else $error("bus acknowledge without status");

    service_restart_a: assert property ( // R10
        ce_in && svc_reg == cwd_pkg::CWD_WAIT_SECOND && wr_svc
        && reg_req_in.wdata == `CWD_SVC_KEY2 |=> cnt_reg == 32'h0)
        else $error("service pair did not restart count");

    ctrl_locked_a: assert property ( // R15
        ce_in && wr_ctrl && ctrl_reg.tif
        |=> ctrl_reg.en == $past(ctrl_reg.en) && ctrl_reg.period == $past(ctrl_reg.period))
        else $error("control written while pending");

    service_keeps_irq_a: assert property ( // R20
        ce_in && irq_out && wr_svc |=> irq_out)
        else $error("service write cleared interrupt");

    wrong_key_a: assert property ( // R22
        ce_in && wr_svc && svc_reg == cwd_pkg::CWD_WAIT_SECOND
        |=> svc_reg == cwd_pkg::CWD_WAIT_FIRST)
        else $error("recogniser did not restart");

    timeout_c:  cover property (ce_in && timeout && !ctrl_reg.tif);
    bus_ack_c:  cover property (bus_ack_out);
    service_c:  cover property (ce_in && svc_done && ctrl_reg.en);
    pin_cause_c: cover property (capt_reg == `CWD_CAPT_DONE && cause_reg.pin);

endmodule

`default_nettype wire

// ==== verilog/cwd_cfg.svh ====
// offsets, bit positions, reset values and timing codes of the core watchdog
// assumes byte-wide registers on the internal peripheral register port
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH

// byte offsets inside the system control register block
`define CWD_OFS_CAUSE     8'h10
`define CWD_OFS_CTRL      8'h11
`define CWD_OFS_SERVICE   8'h13

// reset-cause register bits
`define CWD_PIN_BIT       7
`define CWD_WDOG_BIT      5

// control register bits
`define CWD_EN_BIT        7
`define CWD_ACT_BIT       6
`define CWD_PER_LSB       3
`define CWD_ACKEN_BIT     2
`define CWD_ACKF_BIT      1
`define CWD_TIF_BIT       0

`define CWD_CTRL_RESET    8'h00
`define CWD_CAUSE_RESET   2'h0

// service keys
`define CWD_SVC_KEY1      8'h55
`define CWD_SVC_KEY2      8'hAA

// time-out exponents, bus clocks = 2**exp, code 7 down to code 0
`define CWD_PERIOD_EXP_TABLE {5'h1F, 5'h1B, 5'h17, 5'h13, 5'h0F, 5'h0D, 5'h0B, 5'h09}

// enabled cycles after reset release before the cause is captured
`define CWD_CAPT_AT       2'h2
`define CWD_CAPT_DONE     2'h3

`endif

// ==== verilog/cwd_pkg.sv ====
// types shared by the core watchdog
// assumes nothing beyond the configuration header
`default_nettype none

package cwd_pkg;

    // laid out exactly as the control register, bit 7 down to bit 0
    typedef struct packed {
        logic       en;
        logic       action;
        logic [2:0] period;
        logic       ack_en;
        logic       ack_flag;
        logic       tif;
    } cwd_ctrl_type;

    typedef struct packed {
        logic pin;
        logic wdog;
    } cwd_cause_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cwd_req_type;

    typedef enum logic [1:0] {
        CWD_WAIT_FIRST  = 2'b01,
        CWD_WAIT_SECOND = 2'b10
    } cwd_svc_state_type;

endpackage

`default_nettype wire

// ==== tb/cwd_core_model.sv ====
// core-side model of the watchdog register port
// assumes byte registers and one-cycle strobes on the bus clock
`include "cwd_cfg.svh"
`default_nettype none

module cwd_core_model (
    input  wire logic                  mclk_in,
    input  wire logic [7:0]            rdata_in,
    output var  cwd_pkg::cwd_req_type  req_out,
    output var  logic                  int_ack_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        req_out     = '0;
        int_ack_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // released lines show the inverse, so a stale value never passes
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk_in);
        #1;
        req_out = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk_in);
        #1;
        q       = rdata_in;
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic svc();
        wr(`CWD_OFS_SERVICE, `CWD_SVC_KEY1);
        wr(`CWD_OFS_SERVICE, `CWD_SVC_KEY2);
    endtask

    // period changes only with the timer stopped and freshly serviced
    task automatic reprogram(input logic [7:0] v);
        wr(`CWD_OFS_CTRL, 8'h00);
        svc();
        wr(`CWD_OFS_CTRL, v);
    endtask

    task automatic ack();
        @(posedge mclk_in);
        #1;
        int_ack_out = 1'b1;
        @(posedge mclk_in);
        #1;
        int_ack_out = 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== tb/cwd_core_watchdog_tb.sv ====
// self-checking bench for the core watchdog
// assumes the core model drives the register port
`include "cwd_cfg.svh"
`default_nettype none

module cwd_core_watchdog_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // short exponents, code 7 first, keep the run brief
    localparam logic [39:0] TB_EXP = {5'h0B, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
    localparam logic [7:0]  CT     = `CWD_OFS_CTRL;
    localparam logic [7:0]  SV     = `CWD_OFS_SERVICE;

    logic                 mclk     = 1'b0;
    logic                 arst_n   = 1'b0;
    logic                 ce       = 1'b1;
    logic                 src_pin  = 1'b1;
    logic                 src_wdog = 1'b0;
    cwd_pkg::cwd_req_type req;
    logic                 int_ack;
    logic [7:0]           rdata;
    logic                 irq;
    logic                 bus_ack;
    logic                 rst_req;
    int                   num_errors   = 0;
    int                   total_checks = 0;
    int                   ack_cnt      = 0;
    int                   rst_cnt      = 0;
    int                   k;

    always #2 mclk = ~mclk;

    always @(posedge mclk) begin
        if (bus_ack === 1'b1) ack_cnt <= ack_cnt + 1;
        if (rst_req === 1'b1) rst_cnt <= rst_cnt + 1;
    end

    cwd_core_model m (
        .mclk_in     (mclk),
        .rdata_in    (rdata),
        .req_out     (req),
        .int_ack_out (int_ack)
    );

    cwd_core_watchdog #(.PERIOD_EXP(TB_EXP)) dut (
        .mclk_in            (mclk),
        .arst_n_in          (arst_n),
        .ce_in              (ce),
        .reg_req_in         (req),
        .reg_rdata_out      (rdata),
        .src_pin_reset_in   (src_pin),
        .src_wdog_reset_in  (src_wdog),
        .int_ack_in         (int_ack),
        .irq_out            (irq),
        .bus_ack_out        (bus_ack),
        .wdog_reset_req_out (rst_req)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic int per(input logic [2:0] c);
        return 1 << TB_EXP[c*5 +: 5];
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rdck(input logic [7:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] v;
        m.acc(1'b0, a, 8'h00, v);
        check(nm, v, exp);
    endtask

    // called just after the enabling write's edge; irq is up n edges later
    task automatic expect_to(input int n);
        repeat (n - 1) @(posedge mclk);
        #1;
        check("irq early", {7'h00, irq}, 8'h00);
        @(posedge mclk);
        #1;
        check("irq", {7'h00, irq}, 8'h01);
    endtask

    task automatic wait_irq();
        k = 0;
        while (irq !== 1'b1 && k < 80) begin
            @(posedge mclk);
            #1;
            k++;
        end
        check("irq wait", {7'h00, irq}, 8'h01);
    endtask

    task automatic do_reset(input logic p, input logic w);
        arst_n   = 1'b0;
        src_pin  = p;
        src_wdog = w;
        repeat (20) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(7107));
        do_reset(1'b1, 1'b0);
        rdck(CT, `CWD_CTRL_RESET, "ctrl reset");
        rdck(`CWD_OFS_CAUSE, 8'h80, "cause pin");
        m.wr(`CWD_OFS_CAUSE, 8'h00);
        rdck(`CWD_OFS_CAUSE, 8'h80, "cause w0");
        m.wr(`CWD_OFS_CAUSE, 8'h80);
        rdck(`CWD_OFS_CAUSE, 8'h00, "cause w1c");
        m.wr(8'h20, 8'($urandom));
        rdck(CT, 8'h00, "ctrl after unmapped");
        rdck(SV, 8'h00, "service read");
        // every period code, one with the clock enable dropped
        for (int c = 0; c < 8; c++) begin
            m.reprogram(8'h80 | 8'(c << 3));
            if (c == 1) begin
                k  = 1 + $urandom % 8;
                ce = 1'b0;
                repeat (k) @(posedge mclk);
                #1;
                ce = 1'b1;
            end
            expect_to(per(3'(c)));
            check("no reset", 8'(rst_cnt), 8'h00);
            m.wr(CT, 8'h01);
            rdck(CT, 8'h80 | 8'(c << 3), "tif clear");
        end
        // ordered pairs at random spacing hold the time-out off
        m.reprogram(8'h90);
        repeat (6) begin
            repeat ($urandom % 24) @(posedge mclk);
            m.svc();
        end
        check("serviced", {7'h00, irq}, 8'h00);
        m.wr(SV, `CWD_SVC_KEY1);
        m.wr(SV, `CWD_SVC_KEY1);
        m.wr(SV, `CWD_SVC_KEY2);
        expect_to(per(3'd2) - 6);
        m.svc();
        check("irq kept", {7'h00, irq}, 8'h01);
        m.wr(CT, 8'hC8);
        rdck(CT, 8'h91, "locked");
        m.wr(CT, 8'h01);
        // unacknowledged second period gives one bus acknowledge
        m.reprogram(8'h8C);
        expect_to(per(3'd1));
        k = 0;
        while (bus_ack !== 1'b1 && k < 80) begin
            @(posedge mclk);
            #1;
            k++;
        end
        check("ack delay", 8'(k), 8'(per(3'd1)));
        rdck(CT, 8'h8F, "ack flag");
        m.wr(CT, 8'h03);
        rdck(CT, 8'h8C, "w1c flags");
        wait_irq();
        m.ack();
        repeat (per(3'd1) + 4) @(posedge mclk);
        check("acked", 8'(ack_cnt), 8'h01);
        m.wr(CT, 8'h03);
        // reserved action still requests a reset
        m.reprogram(8'hC0);
        expect_to(per(3'd0));
        @(posedge mclk);
        #1;
        check("reset req", 8'(rst_cnt), 8'h01);
        do_reset(1'b0, 1'b1);
        rdck(`CWD_OFS_CAUSE, 8'h20, "cause wdog");
        do_reset(1'b1, 1'b1);
        rdck(`CWD_OFS_CAUSE, 8'h80, "cause tie");
        end_sim();
    end

    // tests need under ten thousand cycles
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
endmodule

`default_nettype wire
